// ==== verilog/hmw_pkg.sv ====
// shared types and constants of the hall measurement and wake-up sequencer
`default_nettype none
package hmw_pkg;
    localparam int AXIS_W = 12;
    localparam int TEMP_W = 10;
    localparam int CNT_W = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BIAS_SETTLE_NS = 1000;
    localparam int FOSC_START_NS = 500;
    localparam int HALL_BIAS_NS = 2000;
    localparam int INT_PULSE_NS = 1500;
    // least times: round up to whole cycles, never below one
    localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FOSC_START_CYC = (FOSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALL_BIAS_CYC = (HALL_BIAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] MUX_X = 2'h0;
    localparam logic [1:0] MUX_Y = 2'h1;
    localparam logic [1:0] MUX_Z = 2'h2;
    localparam logic [1:0] MUX_T = 2'h3;
    localparam logic [AXIS_W-1:0] AXIS_RST = 12'h000;
    localparam logic [TEMP_W-1:0] TEMP_RST = 10'h000;

    typedef enum logic [3:0] {
        ST_LOWPWR = 4'h0,
        ST_BIAS = 4'h1,
        ST_RSTCHK = 4'h2,
        ST_FOSC = 4'h3,
        ST_HBIAS = 4'h4,
        ST_CONV_X = 4'h5,
        ST_CONV_Y = 4'h6,
        ST_CONV_Z = 4'h7,
        ST_CONV_T = 4'h8,
        ST_DONE = 4'h9,
        ST_RESTART = 4'ha
    } hmw_state_type;

    typedef struct packed {
        logic signed [AXIS_W-1:0] upper;
        logic signed [AXIS_W-1:0] lower;
    } hmw_thr_type;

    typedef struct packed {
        hmw_thr_type x;
        hmw_thr_type y;
        hmw_thr_type z;
    } hmw_wu_thr_type;

    typedef struct packed {
        logic [AXIS_W-1:0] x;
        logic [AXIS_W-1:0] y;
        logic [AXIS_W-1:0] z;
        logic [TEMP_W-1:0] t;
    } hmw_result_type;
endpackage : hmw_pkg
`default_nettype wire

// ==== verilog/hmw_link_events.sv ====
// link-clock side: turns bus event strobes into toggles for the system domain
`timescale 1ns/1ps
`default_nettype none
module hmw_link_events
    import hmw_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic link_rst_i,
    input wire logic cfg_wr_i,
    input wire logic trig_i,
    input wire logic bus_rst_i,
    output logic cfg_tgl_o,
    output logic trig_tgl_o,
    output logic bus_rst_tgl_o
);
    // events only follow master accesses; this end never starts a transfer
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_i)
        begin
            cfg_tgl_o <= 1'b0;
            trig_tgl_o <= 1'b0;
            bus_rst_tgl_o <= 1'b0;
        end
        else
        begin
            cfg_tgl_o <= cfg_tgl_o ^ cfg_wr_i;
            trig_tgl_o <= trig_tgl_o ^ trig_i;
            bus_rst_tgl_o <= bus_rst_tgl_o ^ bus_rst_i;
        end
    end
endmodule : hmw_link_events
`default_nettype wire

// ==== verilog/hmw_measure_ctrl.sv ====
// measurement sequencer and wake-up interrupt of the three-axis hall sensor
`timescale 1ns/1ps
`default_nettype none
module hmw_measure_ctrl
    import hmw_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic LINK_CLK_I,
    input wire logic LINK_RST_I,
    input wire logic LINK_CFG_WR_I,
    input wire logic LINK_TRIG_I,
    input wire logic LINK_BUS_RST_I,
    input wire logic BUS_ACTIVE_I,
    input wire logic SUPPLY_OK_I,
    input wire logic TEMP_EN_I,
    input wire logic CONT_MODE_I,
    input wire logic WAKEUP_EN_I,
    input wire logic COLL_AVOID_EN_I,
    input wire hmw_wu_thr_type WU_THR_I,
    input wire logic ADC_DONE_I,
    input wire logic [AXIS_W-1:0] ADC_DATA_I,
    output logic BIAS_EN_O,
    output logic FOSC_EN_O,
    output logic HALL_BIAS_EN_O,
    output logic ADC_START_O,
    output logic [1:0] MUX_SEL_O,
    output logic LOW_POWER_O,
    output logic BUSY_O,
    output hmw_result_type RESULT_O,
    output logic [2:0] WU_FLAGS_O,
    output logic INT_OUT_O,
    output logic INT_OE_O
);

    function automatic logic out_of_env(input logic [AXIS_W-1:0] val, input hmw_thr_type thr);
        out_of_env = ($signed(val) > thr.upper) || ($signed(val) < thr.lower);
    endfunction : out_of_env

    ////////////////////////////////////////////////////////////////////////////
    // link-domain events and crossings
    logic cfg_tgl;
    logic trig_tgl;
    logic bus_rst_tgl;

    hmw_link_events u_link (
        .link_clk_i(LINK_CLK_I),
        .link_rst_i(LINK_RST_I),
        .cfg_wr_i(LINK_CFG_WR_I),
        .trig_i(LINK_TRIG_I),
        .bus_rst_i(LINK_BUS_RST_I),
        .cfg_tgl_o(cfg_tgl),
        .trig_tgl_o(trig_tgl),
        .bus_rst_tgl_o(bus_rst_tgl)
    );

    logic [2:0] tgl_s1_q;
    logic [2:0] tgl_s2_q;
    logic [2:0] tgl_prev_q;
    logic [1:0] lvl_s1_q;
    logic [1:0] lvl_s2_q;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            tgl_s1_q <= 3'h0;
            tgl_s2_q <= 3'h0;
            tgl_prev_q <= 3'h0;
            lvl_s1_q <= 2'h0;
            lvl_s2_q <= 2'h0;
        end
        else
        begin
            tgl_s1_q <= {bus_rst_tgl, trig_tgl, cfg_tgl};
            tgl_s2_q <= tgl_s1_q;
            tgl_prev_q <= tgl_s2_q;
            lvl_s1_q <= {SUPPLY_OK_I, BUS_ACTIVE_I};
            lvl_s2_q <= lvl_s1_q;
        end
    end

    logic cfg_ev;
    logic trig_ev;
    logic bus_rst_ev;
    logic bus_busy;
    logic supply_ok;

    assign cfg_ev = tgl_s2_q[0] ^ tgl_prev_q[0];
    assign trig_ev = tgl_s2_q[1] ^ tgl_prev_q[1];
    assign bus_rst_ev = tgl_s2_q[2] ^ tgl_prev_q[2];
    assign bus_busy = lvl_s2_q[0];
    assign supply_ok = lvl_s2_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // start requests: an event arriving while a cycle runs is kept for later
    hmw_state_type state_q;
    hmw_state_type state_d;
    logic pending_q;
    logic start_ev;
    logic take_start;

    assign start_ev = cfg_ev | trig_ev;
    assign take_start = (state_q == ST_LOWPWR) && !bus_rst_ev;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || bus_rst_ev)
            pending_q <= 1'b0;
        else if (start_ev)
            pending_q <= 1'b1;
        else if (take_start)
            pending_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    logic [CNT_W-1:0] wait_q;
    logic adc_started_q;
    logic conv_state;
    logic conv_done;

    assign conv_state = (state_q == ST_CONV_X) || (state_q == ST_CONV_Y) ||
        (state_q == ST_CONV_Z) || (state_q == ST_CONV_T);
    assign conv_done = conv_state && adc_started_q && ADC_DONE_I;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_LOWPWR:
                if (pending_q)
                    state_d = ST_BIAS;
            ST_BIAS:
                if (wait_q == '0)
                    state_d = ST_RSTCHK;
            ST_RSTCHK:
                state_d = ST_FOSC;
            ST_FOSC:
                if (wait_q == '0)
                    state_d = ST_HBIAS;
            ST_HBIAS:
                if (wait_q == '0)
                    state_d = ST_CONV_X;
            ST_CONV_X:
                if (conv_done)
                    state_d = ST_CONV_Y;
            ST_CONV_Y:
                if (conv_done)
                    state_d = ST_CONV_Z;
            ST_CONV_Z:
                if (conv_done)
                    state_d = TEMP_EN_I ? ST_CONV_T : ST_DONE;
            ST_CONV_T:
                if (conv_done)
                    state_d = ST_DONE;
            ST_DONE:
                state_d = CONT_MODE_I ? ST_BIAS : ST_LOWPWR;
            ST_RESTART:
                if (supply_ok)
                    state_d = ST_BIAS;
            default:
                state_d = ST_LOWPWR;
        endcase
        // supply loss anywhere in a cycle drops the function and holds
        if (state_q != ST_LOWPWR && !supply_ok)
            state_d = ST_RESTART;
        if (bus_rst_ev)
            state_d = ST_LOWPWR;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            state_q <= ST_LOWPWR;
        else
            state_q <= state_d;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            wait_q <= '0;
        else if (state_d != state_q)
        begin
            case (state_d)
                ST_BIAS: wait_q <= CNT_W'(BIAS_SETTLE_CYC - 1);
                ST_FOSC: wait_q <= CNT_W'(FOSC_START_CYC - 1);
                ST_HBIAS: wait_q <= CNT_W'(HALL_BIAS_CYC - 1);
                default: wait_q <= '0;
            endcase
        end
        else if (wait_q != '0)
            wait_q <= wait_q - 1'b1;
    end

    // one start per conversion; each conversion state entered starts the converter again
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            adc_started_q <= 1'b0;
            ADC_START_O <= 1'b0;
        end
        else
        begin
            ADC_START_O <= conv_state && !adc_started_q && (state_d == state_q);
            if (state_d != state_q)
                adc_started_q <= 1'b0;
            else if (conv_state)
                adc_started_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog enables, all registered from the next state
    logic active_d;
    assign active_d = (state_d != ST_LOWPWR);

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            BIAS_EN_O <= 1'b0;
            FOSC_EN_O <= 1'b0;
            HALL_BIAS_EN_O <= 1'b0;
            MUX_SEL_O <= MUX_X;
            LOW_POWER_O <= 1'b1;
            BUSY_O <= 1'b0;
        end
        else
        begin
            BIAS_EN_O <= active_d;
            // fast clock only from its start step to the end of conversions
            FOSC_EN_O <= (state_d >= ST_FOSC) && (state_d <= ST_CONV_T);
            HALL_BIAS_EN_O <= (state_d >= ST_HBIAS) && (state_d <= ST_CONV_T);
            LOW_POWER_O <= !active_d;
            BUSY_O <= active_d;
            case (state_d)
                ST_CONV_Y: MUX_SEL_O <= MUX_Y;
                ST_CONV_Z: MUX_SEL_O <= MUX_Z;
                ST_CONV_T: MUX_SEL_O <= MUX_T;
                default: MUX_SEL_O <= MUX_X;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results and envelope check
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            RESULT_O <= {AXIS_RST, AXIS_RST, AXIS_RST, TEMP_RST};
        else if (conv_done)
        begin
            case (state_q)
                ST_CONV_X: RESULT_O.x <= ADC_DATA_I;
                ST_CONV_Y: RESULT_O.y <= ADC_DATA_I;
                ST_CONV_Z: RESULT_O.z <= ADC_DATA_I;
                ST_CONV_T: RESULT_O.t <= ADC_DATA_I[AXIS_W-1:AXIS_W-TEMP_W];
                default: RESULT_O <= RESULT_O;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || state_q == ST_BIAS)
            WU_FLAGS_O <= 3'h0;
        else if (conv_done)
        begin
            case (state_q)
                ST_CONV_X: WU_FLAGS_O[0] <= out_of_env(ADC_DATA_I, WU_THR_I.x);
                ST_CONV_Y: WU_FLAGS_O[1] <= out_of_env(ADC_DATA_I, WU_THR_I.y);
                ST_CONV_Z: WU_FLAGS_O[2] <= out_of_env(ADC_DATA_I, WU_THR_I.z);
                default: WU_FLAGS_O <= WU_FLAGS_O;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pulse on the open-drain pin
    logic wu_req;
    logic fire;
    logic [CNT_W-1:0] int_cnt_q;

    assign wu_req = |WU_FLAGS_O;
    // wake-up mode: only out-of-envelope cycles; otherwise every finished cycle
    assign fire = (state_q == ST_DONE) && (WAKEUP_EN_I ? wu_req : 1'b1);

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            int_cnt_q <= '0;
        else if (fire && int_cnt_q == '0 && !(COLL_AVOID_EN_I && bus_busy))
            int_cnt_q <= CNT_W'(INT_PULSE_CYC);
        else if (int_cnt_q != '0)
            int_cnt_q <= int_cnt_q - 1'b1;
    end

    // open-drain: data always low, the enable makes the pulse
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            INT_OE_O <= 1'b0;
            INT_OUT_O <= 1'b0;
        end
        else
        begin
            INT_OE_O <= (int_cnt_q != '0);
            INT_OUT_O <= 1'b0;
        end
    end
endmodule : hmw_measure_ctrl
`default_nettype wire

// ==== verification/hmw_ctrl_monitor.sv ====
// port assertions of the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module hmw_ctrl_monitor
    import hmw_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic SUPPLY_OK_I,
    input wire logic BUS_ACTIVE_I,
    input wire logic COLL_AVOID_EN_I,
    input wire logic TEMP_EN_I,
    input wire logic ADC_DONE_I,
    input wire logic [AXIS_W-1:0] ADC_DATA_I,
    input wire logic ADC_START_O,
    input wire logic [1:0] MUX_SEL_O,
    input wire logic BIAS_EN_O,
    input wire logic FOSC_EN_O,
    input wire logic HALL_BIAS_EN_O,
    input wire logic LOW_POWER_O,
    input wire hmw_result_type RESULT_O,
    input wire logic INT_OUT_O,
    input wire logic INT_OE_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic [7:0] pulse_cnt_q;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || !INT_OE_O)
            pulse_cnt_q <= 8'h00;
        else
            pulse_cnt_q <= pulse_cnt_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////////
    property p_start_single;
        ADC_START_O |-> HALL_BIAS_EN_O ##1
            (!ADC_START_O && ($stable(MUX_SEL_O) || !HALL_BIAS_EN_O));
    endproperty
    a_start_single: assert property (p_start_single) else $error("start pulse wrong");
    property p_pulse_len;
        $fell(INT_OE_O) |-> pulse_cnt_q == 8'(INT_PULSE_CYC);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
    property p_pin_low;
        !INT_OUT_O;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
    property p_supply_hold;
        !SUPPLY_OK_I [*5] |-> !ADC_START_O;
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("convert on low supply");
    property p_coll;
        (COLL_AVOID_EN_I && BUS_ACTIVE_I) [*5] |-> !$rose(INT_OE_O);
    endproperty
    a_coll: assert property (p_coll) else $error("pulse during bus activity");
    property p_fosc;
        HALL_BIAS_EN_O |-> FOSC_EN_O && BIAS_EN_O && !LOW_POWER_O;
    endproperty
    a_fosc: assert property (p_fosc) else $error("fast clock off while measuring");
    property p_idle;
        LOW_POWER_O |-> !FOSC_EN_O && !BIAS_EN_O && !HALL_BIAS_EN_O;
    endproperty
    a_idle: assert property (p_idle) else $error("bias on in low power");
    property p_temp_off;
        ADC_START_O && !TEMP_EN_I |-> MUX_SEL_O != MUX_T;
    endproperty
    a_temp_off: assert property (p_temp_off) else $error("temperature run when off");
    property p_result_x;
        ADC_DONE_I && HALL_BIAS_EN_O && MUX_SEL_O == MUX_X |=> RESULT_O.x == $past(ADC_DATA_I);
    endproperty
    a_result_x: assert property (p_result_x) else $error("x result not stored");
endmodule : hmw_ctrl_monitor
bind hmw_measure_ctrl hmw_ctrl_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
    .SUPPLY_OK_I(SUPPLY_OK_I), .BUS_ACTIVE_I(BUS_ACTIVE_I), .COLL_AVOID_EN_I(COLL_AVOID_EN_I),
    .TEMP_EN_I(TEMP_EN_I), .ADC_DONE_I(ADC_DONE_I), .ADC_DATA_I(ADC_DATA_I),
    .ADC_START_O(ADC_START_O), .MUX_SEL_O(MUX_SEL_O), .BIAS_EN_O(BIAS_EN_O),
    .FOSC_EN_O(FOSC_EN_O), .HALL_BIAS_EN_O(HALL_BIAS_EN_O), .LOW_POWER_O(LOW_POWER_O),
    .RESULT_O(RESULT_O), .INT_OUT_O(INT_OUT_O), .INT_OE_O(INT_OE_O));
`default_nettype wire

// ==== verification/hmw_mcu_model.sv ====
// bus master model: link clock only inside frames and during the link reset, one strobe per frame
`timescale 1ns/1ps
`default_nettype none
module hmw_mcu_model
(
    output logic link_clk_o,
    output logic link_rst_o,
    output logic cfg_wr_o,
    output logic trig_o,
    output logic bus_rst_o,
    output logic bus_active_o
);
    logic in_frame = 1'b0;
    logic hold = 1'b0;
    // no bus traffic at power-up, lines left idle
    assign bus_active_o = in_frame | hold;
    initial
    begin
        link_clk_o = 1'b0;
        link_rst_o = 1'b1;
        {bus_rst_o, trig_o, cfg_wr_o} = 3'h0;
    end
    task automatic tick(input int n);
        repeat (n)
        begin
            #80 link_clk_o = 1'b1;
            #80 link_clk_o = 1'b0;
        end
    endtask : tick
    task automatic reset_link();
        #37 tick(3);
        link_rst_o = 1'b0;
    endtask : reset_link
    // master opens every transfer; strobes change after a falling edge
    task automatic frame(input logic [2:0] ev);
        in_frame = 1'b1;
        tick(1);
        {bus_rst_o, trig_o, cfg_wr_o} = ev;
        tick(1);
        {bus_rst_o, trig_o, cfg_wr_o} = 3'h0;
        tick(2);
        in_frame = 1'b0;
    endtask : frame
endmodule : hmw_mcu_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    import hmw_pkg::*;
    localparam logic [AXIS_W-1:0] THR_HI = 12'h100;
    localparam logic [AXIS_W-1:0] THR_LO = 12'hf00;
    logic CLK_SYS_I, RST_I, LINK_CLK_I, LINK_RST_I, LINK_CFG_WR_I, LINK_TRIG_I, LINK_BUS_RST_I;
    logic BUS_ACTIVE_I, SUPPLY_OK_I, TEMP_EN_I, CONT_MODE_I, WAKEUP_EN_I, COLL_AVOID_EN_I;
    logic ADC_DONE_I, BIAS_EN_O, FOSC_EN_O, HALL_BIAS_EN_O, ADC_START_O, LOW_POWER_O, BUSY_O;
    logic INT_OUT_O, INT_OE_O;
    logic [AXIS_W-1:0] ADC_DATA_I;
    logic [1:0] MUX_SEL_O;
    logic [2:0] WU_FLAGS_O;
    hmw_wu_thr_type WU_THR_I;
    hmw_result_type RESULT_O;
    logic [AXIS_W-1:0] smp [4];
    logic [TEMP_W-1:0] exp_t;
    int adc_cnt = 0;
    int cyc = 0;
    int k = 0;
    int n_mismatch = 0;
    int n_compared = 0;
    hmw_mcu_model mcu (.link_clk_o(LINK_CLK_I), .link_rst_o(LINK_RST_I), .cfg_wr_o(LINK_CFG_WR_I),
        .trig_o(LINK_TRIG_I), .bus_rst_o(LINK_BUS_RST_I), .bus_active_o(BUS_ACTIVE_I));
    hmw_measure_ctrl uut (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .LINK_CLK_I(LINK_CLK_I),
        .LINK_RST_I(LINK_RST_I), .LINK_CFG_WR_I(LINK_CFG_WR_I), .LINK_TRIG_I(LINK_TRIG_I),
        .LINK_BUS_RST_I(LINK_BUS_RST_I), .BUS_ACTIVE_I(BUS_ACTIVE_I), .SUPPLY_OK_I(SUPPLY_OK_I),
        .TEMP_EN_I(TEMP_EN_I), .CONT_MODE_I(CONT_MODE_I), .WAKEUP_EN_I(WAKEUP_EN_I),
        .COLL_AVOID_EN_I(COLL_AVOID_EN_I), .WU_THR_I(WU_THR_I), .ADC_DONE_I(ADC_DONE_I),
        .ADC_DATA_I(ADC_DATA_I), .BIAS_EN_O(BIAS_EN_O), .FOSC_EN_O(FOSC_EN_O),
        .HALL_BIAS_EN_O(HALL_BIAS_EN_O), .ADC_START_O(ADC_START_O), .MUX_SEL_O(MUX_SEL_O),
        .LOW_POWER_O(LOW_POWER_O), .BUSY_O(BUSY_O), .RESULT_O(RESULT_O), .WU_FLAGS_O(WU_FLAGS_O),
        .INT_OUT_O(INT_OUT_O), .INT_OE_O(INT_OE_O));
    always #25 CLK_SYS_I = ~CLK_SYS_I;
    ////////////////////////////////////////////////////////////////
    // converter: done three cycles after start, data scrambled when not valid
    always @(negedge CLK_SYS_I)
    begin
        ADC_DONE_I = 1'b0;
        if (ADC_START_O)
            adc_cnt = 3;
        else if (adc_cnt > 0)
        begin
            adc_cnt--;
            ADC_DONE_I = (adc_cnt == 0);
        end
        ADC_DATA_I = ADC_DONE_I ? smp[MUX_SEL_O] : ~smp[MUX_SEL_O];
    end
    always @(posedge CLK_SYS_I)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    function automatic logic outside(input logic [AXIS_W-1:0] v);
        return ($signed(v) > $signed(THR_HI)) || ($signed(v) < $signed(THR_LO));
    endfunction : outside
    task automatic cycle(input logic [2:0] ev, input logic [AXIS_W-1:0] x, y, z);
        int i;
        logic seen;
        logic [2:0] fl;
        logic exp_int;
        smp[0] = x;
        smp[1] = y;
        smp[2] = z;
        smp[3] = smp[3] + 12'h104;
        if (TEMP_EN_I)
            exp_t = smp[3][11:2];
        fl = {outside(z), outside(y), outside(x)};
        exp_int = (WAKEUP_EN_I ? |fl : 1'b1) & !(COLL_AVOID_EN_I & mcu.hold);
        seen = 1'b0;
        mcu.frame(ev);
        for (i = 0; i < 60 && BUSY_O !== 1'b1; i++)
            @(negedge CLK_SYS_I);
        for (i = 0; i < 600 && BUSY_O !== 1'b0; i++)
            @(negedge CLK_SYS_I);
        repeat (40)
        begin
            @(negedge CLK_SYS_I);
            seen = seen | INT_OE_O;
        end
        `CHK("result_x", x, RESULT_O.x)
        `CHK("result_y", y, RESULT_O.y)
        `CHK("result_z", z, RESULT_O.z)
        `CHK("result_t", exp_t, RESULT_O.t)
        `CHK("wu_flags", fl, WU_FLAGS_O)
        `CHK("int_pulse", exp_int, seen)
    endtask : cycle
    initial
    begin
        // the clock process only inverts, so it needs a known start level
        CLK_SYS_I = 1'b0;
        {RST_I, SUPPLY_OK_I, TEMP_EN_I} = 3'h7;
        {CONT_MODE_I, WAKEUP_EN_I, COLL_AVOID_EN_I} = 3'h0;
        WU_THR_I = {3{THR_HI, THR_LO}};
        smp = '{12'h000, 12'h000, 12'h000, 12'h000};
        fork
            mcu.reset_link();
            repeat (16) @(posedge CLK_SYS_I);
        join
        @(negedge CLK_SYS_I);
        RST_I = 1'b0;
        repeat (3) @(negedge CLK_SYS_I);
        `CHK("low_power", 1'b1, LOW_POWER_O)
        `CHK("fosc_idle", 1'b0, FOSC_EN_O)
        `CHK("busy_idle", 1'b0, BUSY_O)
        cycle(3'h1, 12'h123, 12'h456, 12'h789);
        cycle(3'h2, 12'h0ff, 12'hf00, 12'h001);
        WAKEUP_EN_I = 1'b1;
        cycle(3'h1, 12'h010, 12'hff0, 12'h100);
        cycle(3'h1, 12'h010, 12'h101, 12'h020);
        cycle(3'h1, 12'h200, 12'h010, 12'hd00);
        TEMP_EN_I = 1'b0;
        cycle(3'h1, 12'h011, 12'h022, 12'h033);
        TEMP_EN_I = 1'b1;
        COLL_AVOID_EN_I = 1'b1;
        mcu.hold = 1'b1;
        cycle(3'h1, 12'h300, 12'h010, 12'h010);
        mcu.hold = 1'b0;
        fork
            cycle(3'h1, 12'h200, 12'h010, 12'h020);
            begin
                repeat (95) @(negedge CLK_SYS_I);
                SUPPLY_OK_I = 1'b0;
                repeat (10) @(negedge CLK_SYS_I);
                `CHK("restart_hold", 1'b0, HALL_BIAS_EN_O)
                SUPPLY_OK_I = 1'b1;
            end
        join
        // continuous mode: the finished cycle must not drop back to low power
        CONT_MODE_I = 1'b1;
        mcu.frame(3'h1);
        for (k = 0; k < 400 && INT_OE_O !== 1'b1; k++)
            @(negedge CLK_SYS_I);
        `CHK("cont_pulse", 1'b1, INT_OE_O)
        `CHK("cont_busy", 1'b1, BUSY_O)
        CONT_MODE_I = 1'b0;
        mcu.frame(3'h1);
        repeat (30) @(negedge CLK_SYS_I);
        mcu.frame(3'h4);
        repeat (10) @(negedge CLK_SYS_I);
        `CHK("abort_idle", 1'b1, LOW_POWER_O)
        `CHK("abort_fosc", 1'b0, FOSC_EN_O)
        end_sim();
    end
endmodule : tb
`default_nettype wire
